// ==== hw/rsi_pkg.sv ====
package rsi_pkg;
    // Register indices; byte address is four times the index
    localparam logic [7:0] IDX_PULLDOWN  = 8'h0b;
    localparam logic [7:0] IDX_OPENDRAIN = 8'h0c;
    localparam logic [7:0] IDX_PULLUP    = 8'h0d;
    localparam logic [7:0] IDX_WDEDGE    = 8'h0e;
    localparam logic [7:0] IDX_MASK      = 8'h0f;
    localparam logic [7:0] IDX_FLAGS     = 8'h10;
    localparam logic [7:0] IDX_STATUS    = 8'h11;
    localparam logic [7:0] A_PULLDOWN    = 8'(IDX_PULLDOWN * 4);
    localparam logic [7:0] A_OPENDRAIN   = 8'(IDX_OPENDRAIN * 4);
    localparam logic [7:0] A_PULLUP      = 8'(IDX_PULLUP * 4);
    localparam logic [7:0] A_WDEDGE      = 8'(IDX_WDEDGE * 4);
    localparam logic [7:0] A_MASK        = 8'(IDX_MASK * 4);
    localparam logic [7:0] A_FLAGS       = 8'(IDX_FLAGS * 4);
    localparam logic [7:0] A_STATUS      = 8'(IDX_STATUS * 4);
    // Reset values
    localparam logic [7:0] PULLDOWN_RST  = 8'hf7;
    localparam logic [7:0] OPENDRAIN_RST = 8'h00;
    localparam logic [7:0] PULLUP_RST    = 8'hff;
    localparam logic [7:0] WDEDGE_RST    = 8'h80;
    localparam logic [2:0] IRQ_RST       = 3'h0;
    // Interrupt bit positions
    localparam int BIT_TMR  = 0;
    localparam int BIT_PORT = 1;
    localparam int BIT_EXT  = 2;
    // Watchdog/edge control bits
    localparam int BIT_WDTE = 7;
    localparam int BIT_EIS  = 6;
    // Status register bits
    localparam int ST_DOZE   = 0;
    localparam int ST_EXPIRY = 1;
    localparam int ST_SLEEP  = 2;
    localparam int ST_GIE    = 3;
    // Vectors
    localparam logic [7:0] VEC_IRQ  = 8'h08;
    localparam logic [7:0] VEC_TRAP = 8'h01;
    // Power state
    typedef enum logic {PS_RUN, PS_SLEEP} power_state_t;
endpackage

// ==== hw/reset_status_and_interrupt_logic.sv ====
`timescale 1ns/1ns
module reset_status_and_interrupt_logic
    import rsi_pkg::*;
(
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic        reset_pin_n,
    input  wire logic [7:0]  port6_pins,
    input  wire logic [7:0]  port6_is_input,
    input  wire logic        port6_read,
    input  wire logic        timer_ovf,
    input  wire logic        watchdog_expire,
    input  wire logic        watchdog_clear,
    input  wire logic        sleep_instr,
    input  wire logic        global_irq_on,
    input  wire logic        global_irq_off,
    input  wire logic        irq_return,
    input  wire logic        soft_trap_instr,
    output logic             core_reset,
    output logic             vector_take,
    output logic      [7:0]  vector_addr,
    output logic             resume_next,
    output logic      [2:0]  irq_request,
    output logic             watchdog_enable,
    output logic      [7:0]  port_pulldown_n,
    output logic      [7:0]  port_open_drain,
    output logic      [7:0]  port_pullup_n
);
    // Synchroniser stages: bit 8 is the reset pin, 7:0 port 6
    logic [8:0]   sync1_reg;
    logic [8:0]   sync2_reg;
    logic [8:0]   sync3_reg;
    logic [8:0]   stable_reg;        // Agreed pin levels
    logic         rst_prev_reg;      // Reset pin level last cycle
    logic         ext_prev_reg;      // Interrupt pin level last cycle
    logic         tmr_prev_reg;      // Timer overflow last cycle
    logic [7:0]   ref_reg;           // Port change reference
    logic [2:0]   flags_reg;         // Pending requests
    logic [2:0]   mask_reg;          // Per-source enables
    logic [7:0]   pulldown_reg;
    logic [7:0]   opendrain_reg;
    logic [7:0]   pullup_reg;
    logic [7:0]   wdedge_reg;        // Watchdog enable and pin select
    logic         expiry_reg;
    logic         doze_reg;
    logic         gie_reg;           // Global interrupt enable
    power_state_t state_reg;
    logic [31:0]  prdata_reg;
    logic         pslverr_reg;
    logic         core_reset_reg;
    logic         vector_take_reg;
    logic [7:0]   vector_addr_reg;
    logic         resume_reg;
    logic [2:0]   irq_req_reg;

    // Next values
    logic [2:0]   flags_next;
    logic         expiry_next;
    logic         doze_next;
    logic         gie_next;
    power_state_t state_next;

    // Three-stage pin synchronisers; level counts once stages 2 and 3 agree
    genvar gi;
    generate
        for (gi = 0; gi < 9; gi++) begin : g_sync
            always_ff @(posedge pclk or negedge presetn) begin
                if (!presetn) begin
                    sync1_reg[gi]  <= 1'b1;
                    sync2_reg[gi]  <= 1'b1;
                    sync3_reg[gi]  <= 1'b1;
                    stable_reg[gi] <= 1'b1;
                end else begin
                    sync1_reg[gi] <= (gi == 8) ? reset_pin_n : port6_pins[gi % 8];
                    sync2_reg[gi] <= sync1_reg[gi];
                    sync3_reg[gi] <= sync2_reg[gi];
                    if (sync2_reg[gi] == sync3_reg[gi]) begin
                        stable_reg[gi] <= sync3_reg[gi];
                    end
                end
            end
        end
    endgenerate

    // Event decode
    wire       sleeping   = (state_reg == PS_SLEEP);
    wire       running    = (state_reg == PS_RUN);
    wire       eis        = wdedge_reg[BIT_EIS];
    wire       pin_event  = stable_reg[8] & ~rst_prev_reg;
    wire       wdt_event  = watchdog_expire & ~pin_event;
    wire       soft_rst   = pin_event | watchdog_expire;
    wire       ext_fall   = eis & ext_prev_reg & ~stable_reg[0];
    wire       tmr_fall   = tmr_prev_reg & ~timer_ovf;
    wire [7:0] port_qual  = port6_is_input & ~{7'h00, eis};
    wire       port_hit   = |((stable_reg[7:0] ^ ref_reg) & port_qual);
    wire       port_set   = port_hit & mask_reg[BIT_PORT];
    wire       port_wake  = sleeping & port_set & ~soft_rst;
    wire       wake       = sleeping & (soft_rst | port_set);
    wire [2:0] irq_pend   = flags_reg & mask_reg;
    wire       dispatch   = running & gie_reg & (|irq_pend) & ~soft_rst;
    wire       trap       = running & gie_reg & soft_trap_instr & ~dispatch & ~soft_rst;
    wire       wake_vec   = wake & gie_reg;

    // Bus decode
    wire       setup      = psel & ~penable;
    wire       wr         = psel & penable & pwrite;
    wire       wr_pd      = wr & (paddr == A_PULLDOWN);
    wire       wr_od      = wr & (paddr == A_OPENDRAIN);
    wire       wr_pu      = wr & (paddr == A_PULLUP);
    wire       wr_we      = wr & (paddr == A_WDEDGE);
    wire       wr_mask    = wr & (paddr == A_MASK);
    wire       wr_flags   = wr & (paddr == A_FLAGS);
    wire [2:0] clr_keep   = wr_flags ? pwdata[2:0] : 3'h7;
    wire [2:0] set_vec    = {ext_fall, port_set, tmr_fall};
    wire [7:0] status_rd  = {4'h0, gie_reg, sleeping, expiry_reg, doze_reg};
    logic [31:0] rd_mux;
    logic        rd_hit;

    // Read mux
    always_comb begin
        rd_hit = 1'b1;
        rd_mux = 32'h0000_0000;
        if (paddr == A_PULLDOWN) begin
            rd_mux = {24'h000000, pulldown_reg};
        end else if (paddr == A_OPENDRAIN) begin
            rd_mux = {24'h000000, opendrain_reg};
        end else if (paddr == A_PULLUP) begin
            rd_mux = {24'h000000, pullup_reg};
        end else if (paddr == A_WDEDGE) begin
            rd_mux = {24'h000000, wdedge_reg};
        end else if (paddr == A_MASK) begin
            rd_mux = {29'h0000_0000, mask_reg};
        end else if (paddr == A_FLAGS) begin
            rd_mux = {29'h0000_0000, flags_reg};
        end else if (paddr == A_STATUS) begin
            rd_mux = {24'h000000, status_rd};
        end else begin
            rd_hit = 1'b0;
        end
    end

    // Flags: writing 0 clears, a same-cycle event wins, reset-type event clears
    always_comb begin
        if (soft_rst) begin
            flags_next = IRQ_RST;
        end else begin
            flags_next = (flags_reg & clr_keep) | set_vec;
        end
    end

    // Timeout and power-down flags
    always_comb begin
        expiry_next = expiry_reg;
        doze_next   = doze_reg;
        if (pin_event) begin
            if (sleeping) begin
                expiry_next = 1'b1;
                doze_next   = 1'b0;
            end
        end else if (watchdog_expire) begin
            expiry_next = 1'b0;
            if (sleeping) begin
                doze_next = 1'b0;
            end
        end else if (port_wake) begin
            expiry_next = 1'b1;
            doze_next   = 1'b0;
        end else if (watchdog_clear) begin
            expiry_next = 1'b1;
            doze_next   = 1'b1;
        end else if (sleep_instr & running) begin
            expiry_next = 1'b1;
            doze_next   = 1'b0;
        end
    end

    // Global enable; entry to a handler clears it
    always_comb begin
        if (soft_rst | dispatch | trap | wake_vec) begin
            gie_next = 1'b0;
        end else if (global_irq_on | irq_return) begin
            gie_next = 1'b1;
        end else if (global_irq_off) begin
            gie_next = 1'b0;
        end else begin
            gie_next = gie_reg;
        end
    end

    // Sleep state
    always_comb begin
        case (state_reg)
            PS_RUN:   state_next = (sleep_instr & ~soft_rst) ? PS_SLEEP : PS_RUN;
            PS_SLEEP: state_next = wake ? PS_RUN : PS_SLEEP;
            default:  state_next = PS_RUN;
        endcase
    end

    // Edge history and port reference
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rst_prev_reg <= 1'b1;
            ext_prev_reg <= 1'b1;
            tmr_prev_reg <= 1'b0;
            ref_reg      <= 8'hff;
        end else begin
            rst_prev_reg <= stable_reg[8];
            ext_prev_reg <= stable_reg[0];
            tmr_prev_reg <= timer_ovf;
            if (port6_read) begin
                ref_reg <= stable_reg[7:0];
            end
        end
    end

    // Interrupt and status state; power-on sets both status flags
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            flags_reg  <= IRQ_RST;
            expiry_reg <= 1'b1;
            doze_reg   <= 1'b1;
            gie_reg    <= 1'b0;
            state_reg  <= PS_RUN;
        end else begin
            flags_reg  <= flags_next;
            expiry_reg <= expiry_next;
            doze_reg   <= doze_next;
            gie_reg    <= gie_next;
            state_reg  <= state_next;
        end
    end

    // Control registers; reset-type events restore them, port wake keeps all but the watchdog enable bit, which it sets
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mask_reg      <= IRQ_RST;
            pulldown_reg  <= PULLDOWN_RST;
            opendrain_reg <= OPENDRAIN_RST;
            pullup_reg    <= PULLUP_RST;
            wdedge_reg    <= WDEDGE_RST;
        end else if (soft_rst) begin
            mask_reg      <= IRQ_RST;
            pulldown_reg  <= PULLDOWN_RST;
            opendrain_reg <= OPENDRAIN_RST;
            pullup_reg    <= PULLUP_RST;
            wdedge_reg    <= WDEDGE_RST;
        end else begin
            if (wr_mask) mask_reg <= pwdata[2:0];
            if (wr_pd) pulldown_reg <= pwdata[7:0];
            if (wr_od) opendrain_reg <= pwdata[7:0];
            if (wr_pu) pullup_reg <= pwdata[7:0];
            if (wake) begin
                wdedge_reg[BIT_WDTE] <= 1'b1; // Watchdog re-enables on wake
            end else if (wr_we) begin
                wdedge_reg <= pwdata[7:0];
            end
        end
    end

    // Bus answers: read data and error latched in setup, zero wait states
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata_reg  <= 32'h0000_0000;
            pslverr_reg <= 1'b0;
        end else if (setup) begin
            prdata_reg  <= pwrite ? 32'h0000_0000 : rd_mux;
            pslverr_reg <= ~rd_hit;
        end
    end

    // Core-facing outputs
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            core_reset_reg  <= 1'b1;
            vector_take_reg <= 1'b0;
            vector_addr_reg <= VEC_IRQ;
            resume_reg      <= 1'b0;
            irq_req_reg     <= IRQ_RST;
        end else begin
            core_reset_reg  <= soft_rst;
            vector_take_reg <= dispatch | trap | wake_vec;
            vector_addr_reg <= trap ? VEC_TRAP : VEC_IRQ;
            resume_reg      <= wake & ~gie_reg;
            irq_req_reg     <= irq_pend;
        end
    end

    assign prdata          = prdata_reg;
    assign pready          = 1'b1;
    assign pslverr         = pslverr_reg;
    assign core_reset      = core_reset_reg;
    assign vector_take     = vector_take_reg;
    assign vector_addr     = vector_addr_reg;
    assign resume_next     = resume_reg;
    assign irq_request     = irq_req_reg;
    assign watchdog_enable = wdedge_reg[BIT_WDTE];
    assign port_pulldown_n = pulldown_reg;
    assign port_open_drain = opendrain_reg;
    assign port_pullup_n   = pullup_reg;

    // Checks
    sequence s_pin_sleep;
        pin_event && sleeping;
    endsequence
    sequence s_wdt_run;
        wdt_event && running;
    endsequence
    sequence s_entry;
        dispatch ##1 vector_take_reg && (vector_addr_reg == VEC_IRQ);
    endsequence

    a_reset_pulse: assert property (@(posedge pclk) disable iff (!presetn)
        soft_rst |=> core_reset_reg ##1 (irq_req_reg == IRQ_RST) && (!core_reset_reg || $past(soft_rst)))
        else $error("reset event did not pulse core reset");
    a_pin_run: assert property (@(posedge pclk) disable iff (!presetn)
        (pin_event && running) |=> (expiry_reg == $past(expiry_reg)) && (doze_reg == $past(doze_reg)))
        else $error("pin reset changed status flags");
    a_pin_wake: assert property (@(posedge pclk) disable iff (!presetn)
        s_pin_sleep |=> expiry_reg && !doze_reg && running)
        else $error("pin wake flags wrong");
    a_wdt_run: assert property (@(posedge pclk) disable iff (!presetn)
        s_wdt_run |=> !expiry_reg && (doze_reg == $past(doze_reg)))
        else $error("watchdog run flags wrong");
    a_wdt_wake: assert property (@(posedge pclk) disable iff (!presetn)
        (wdt_event && sleeping) |=> !expiry_reg && !doze_reg)
        else $error("watchdog wake flags wrong");
    a_port_wake: assert property (@(posedge pclk) disable iff (!presetn)
        port_wake |=> expiry_reg && !doze_reg && (vector_take_reg != resume_reg))
        else $error("port wake result wrong");
    a_sleep_flags: assert property (@(posedge pclk) disable iff (!presetn)
        (sleep_instr && running && !soft_rst && !watchdog_clear) |=> sleeping && expiry_reg && !doze_reg)
        else $error("sleep entry flags wrong");
    a_irq_entry: assert property (@(posedge pclk) disable iff (!presetn)
        dispatch |-> s_entry)
        else $error("interrupt did not vector to 008H");
    a_tmr_sticky: assert property (@(posedge pclk) disable iff (!presetn)
        (tmr_fall && !soft_rst) |=> flags_reg[BIT_TMR] ##1 (flags_reg[BIT_TMR] || $past(wr_flags || soft_rst)))
        else $error("timer flag not set or not held");
    a_port_gate: assert property (@(posedge pclk) disable iff (!presetn)
        (!mask_reg[BIT_PORT] && !flags_reg[BIT_PORT]) |=> !flags_reg[BIT_PORT])
        else $error("port flag set while disabled");
    a_req_and: assert property (@(posedge pclk) disable iff (!presetn)
        ##1 irq_req_reg == ($past(flags_reg) & $past(mask_reg)))
        else $error("request is not flags and mask");
    a_gie_on: assert property (@(posedge pclk) disable iff (!presetn)
        ((global_irq_on || irq_return) && !(soft_rst || dispatch || trap || wake_vec)) |=> gie_reg)
        else $error("global enable not set");
    a_trap_vec: assert property (@(posedge pclk) disable iff (!presetn)
        trap |=> vector_take_reg && (vector_addr_reg == VEC_TRAP) && !gie_reg)
        else $error("soft trap did not vector to 001H");
endmodule

// ==== verif/core_model.sv ====
`timescale 1ns/1ns
// Core sequencer stand-in: issues one-cycle instruction pulses, logs vectors
module core_model (
    input  wire logic       pclk,
    input  wire logic       presetn,
    input  wire logic       vector_take,
    input  wire logic [7:0] vector_addr,
    input  wire logic       resume_next,
    output logic      [7:0] ev
);
    int         vec_cnt;   // Vector fetches seen
    int         res_cnt;   // Resume-after-sleep pulses seen
    logic [7:0] last_vec;  // Address of last vector fetch

    initial begin
        ev       = 8'h00;
        vec_cnt  = 0;
        res_cnt  = 0;
        last_vec = 8'h00;
    end

    // One pulse per call; waits an edge first so pulses never merge
    task automatic fire(input int i);
        @(posedge pclk);
        ev[i] <= 1'b1;
        @(posedge pclk);
        ev <= 8'h00;
    endtask

    // Log the redirects the block asks of the core
    always @(posedge pclk) begin
        if (presetn === 1'b1 && vector_take === 1'b1) begin
            vec_cnt++;
            last_vec <= vector_addr;
        end
        if (presetn === 1'b1 && resume_next === 1'b1) begin
            res_cnt++;
        end
    end
endmodule

// ==== verif/reset_status_and_interrupt_logic_bench.sv ====
`timescale 1ns/1ns
module reset_status_and_interrupt_logic_bench;
    import rsi_pkg::*;
    logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
    logic [7:0]  paddr, port6_pins, port6_is_input, vector_addr, ev;
    logic [31:0] pwdata, prdata;
    logic        reset_pin_n, timer_ovf, core_reset, vector_take, resume_next;
    logic [2:0]  irq_request;
    logic        watchdog_enable;
    logic [7:0]  port_pulldown_n, port_open_drain, port_pullup_n;
    int          error_cnt, check_count;
    int          rst_seen = 0;          // Core reset pulses seen after release
    // Core instruction pulses, one net each
    wire         wd_expire_ev = ev[0];
    wire         wd_clear_ev  = ev[1];
    wire         sleep_ev     = ev[2];
    wire         irq_on_ev    = ev[3];
    wire         irq_off_ev   = ev[4];
    wire         ret_ev       = ev[5];
    wire         trap_ev      = ev[6];
    wire         port_rd_ev   = ev[7];

    // Clock, 100 MHz
    initial begin
        pclk = 1'b0;
        forever #5 pclk = ~pclk;
    end

    core_model core (.pclk(pclk), .presetn(presetn), .vector_take(vector_take), .vector_addr(vector_addr),
                     .resume_next(resume_next), .ev(ev));

    reset_status_and_interrupt_logic uut (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .reset_pin_n(reset_pin_n),
        .port6_pins(port6_pins), .port6_is_input(port6_is_input), .port6_read(port_rd_ev), .timer_ovf(timer_ovf),
        .watchdog_expire(wd_expire_ev), .watchdog_clear(wd_clear_ev), .sleep_instr(sleep_ev),
        .global_irq_on(irq_on_ev), .global_irq_off(irq_off_ev), .irq_return(ret_ev),
        .soft_trap_instr(trap_ev), .core_reset(core_reset),
        .vector_take(vector_take), .vector_addr(vector_addr), .resume_next(resume_next),
        .irq_request(irq_request), .watchdog_enable(watchdog_enable), .port_pulldown_n(port_pulldown_n),
        .port_open_drain(port_open_drain), .port_pullup_n(port_pullup_n));

    // Compare and count
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp) begin
            error_cnt++;
            $display("BAD %0t got %h expected %h", $time, got, exp);
        end
    endtask

    // One APB transfer: setup, then access until pready
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d,
                       output logic [31:0] q, output logic e);
        @(posedge pclk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= wr;
        paddr   <= a;
        pwdata  <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        q = prdata;
        e = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] q;
        logic        e;
        apb(1'b1, a, d, q, e);
    endtask

    task automatic rd(input logic [7:0] a, input logic [31:0] exp);
        logic [31:0] q;
        logic        e;
        apb(1'b0, a, 32'h0, q, e);
        chk(q, exp);
    endtask

    // Pin sync needs a few cycles to land
    task automatic settle;
        repeat (10) @(posedge pclk);
    endtask

    // High-low-high pulse on the reset pin
    task automatic pin_pulse;
        @(posedge pclk);
        reset_pin_n <= 1'b0;
        repeat (4) @(posedge pclk);
        reset_pin_n <= 1'b1;
        settle();
    endtask

    task automatic stop_test;
        $display("checks %0d mismatches %0d", check_count, error_cnt);
        if (error_cnt == 0 && check_count > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask

    // Count core reset pulses once out of power-on reset
    always @(posedge pclk) begin
        if (presetn === 1'b1 && core_reset === 1'b1) begin
            rst_seen++;
        end
    end

    // Hang guard
    initial begin
        #200000;
        error_cnt++;
        stop_test();
    end

    // Main sequence
    initial begin
        logic [7:0]  ra [7] = '{A_PULLDOWN, A_OPENDRAIN, A_PULLUP, A_WDEDGE, A_MASK, A_FLAGS, A_STATUS};
        logic [31:0] rv [7] = '{32'hf7, 32'h0, 32'hff, 32'h80, 32'h0, 32'h0, 32'h3};
        logic [31:0] q;
        logic        e;
        int          r0;
        error_cnt = 0;
        check_count = 0;
        {psel, penable, pwrite, timer_ovf} = 4'h0;
        paddr = 8'h00;
        pwdata = 32'h0;
        reset_pin_n = 1'b1;
        port6_pins = 8'hff;
        port6_is_input = 8'h0e;
        presetn = 1'b0;
        repeat (12) @(posedge pclk);
        presetn <= 1'b1;
        for (int i = 0; i < 7; i++) rd(ra[i], rv[i]);
        apb(1'b0, 8'h80, 32'h0, q, e);
        chk(32'(e), 32'h1);
        chk(32'(port_pulldown_n), 32'hf7);
        chk(32'(port_open_drain), 32'h00);
        chk(32'(port_pullup_n), 32'hff);
        chk(32'(watchdog_enable), 32'h1);
        $display("test reset values done");
        // Timer event, mask, dispatch, clear, return, trap
        timer_ovf <= 1'b1;
        settle();
        timer_ovf <= 1'b0;
        settle();
        rd(A_FLAGS, 32'h1);
        chk(32'(irq_request), 32'h0);
        wr(A_MASK, 32'h1);
        settle();
        chk(32'(irq_request), 32'h1);
        core.fire(3);
        settle();
        chk(32'(core.vec_cnt), 32'h1);
        chk(32'(core.last_vec), 32'h08);
        wr(A_FLAGS, 32'h0);
        rd(A_FLAGS, 32'h0);
        core.fire(5);
        rd(A_STATUS, 32'hb);
        core.fire(6);
        settle();
        chk(32'(core.last_vec), 32'h01);
        core.fire(3);
        core.fire(4);
        rd(A_STATUS, 32'h3);
        $display("test interrupts done");
        // Watchdog and pin resets while running
        wr(A_MASK, 32'h7);
        wr(A_OPENDRAIN, 32'h5a);
        wr(A_PULLUP, 32'h0f);
        wr(A_PULLDOWN, 32'h33);
        rd(A_PULLDOWN, 32'h33);
        chk(32'(port_open_drain), 32'h5a);
        chk(32'(port_pullup_n), 32'h0f);
        chk(32'(port_pulldown_n), 32'h33);
        r0 = rst_seen;
        core.fire(0);
        settle();
        chk(32'(rst_seen - r0), 32'h1);
        rd(A_MASK, 32'h0);
        chk(32'(port_open_drain), 32'h00);
        chk(32'(port_pullup_n), 32'hff);
        chk(32'(port_pulldown_n), 32'hf7);
        rd(A_STATUS, 32'h1);
        r0 = rst_seen;
        pin_pulse();
        chk(32'(rst_seen - r0), 32'h1);
        rd(A_STATUS, 32'h1);
        $display("test running resets done");
        // Wakes from sleep
        core.fire(2);
        rd(A_STATUS, 32'h6);
        pin_pulse();
        rd(A_STATUS, 32'h2);
        chk(32'(core.res_cnt), 32'h1);
        core.fire(1);
        rd(A_STATUS, 32'h3);
        core.fire(2);
        core.fire(0);
        settle();
        rd(A_STATUS, 32'h0);
        chk(32'(core.res_cnt), 32'h2);
        core.fire(1);
        core.fire(7);
        wr(A_MASK, 32'h2);
        wr(A_WDEDGE, 32'h0);
        core.fire(3);
        chk(32'(watchdog_enable), 32'h0);
        core.fire(2);
        port6_pins[7] <= 1'b0;
        settle();
        rd(A_STATUS, 32'he);
        port6_pins[2] <= 1'b0;
        settle();
        chk(32'(core.last_vec), 32'h08);
        chk(32'(core.vec_cnt), 32'h3);
        rd(A_STATUS, 32'h2);
        rd(A_FLAGS, 32'h2);
        chk(32'(watchdog_enable), 32'h1);
        rd(A_WDEDGE, 32'h80);
        $display("test sleep wakes done");
        // External pin falling edge; pin 0 as input must stay out of the change compare
        port6_is_input <= 8'h0f;
        core.fire(7);
        wr(A_FLAGS, 32'h0);
        wr(A_WDEDGE, 32'hc0);
        port6_pins[0] <= 1'b0;
        settle();
        rd(A_FLAGS, 32'h4);
        $display("test external pin done");
        // Power-on reset again in mid-run
        presetn <= 1'b0;
        repeat (2) @(posedge pclk);
        chk(32'(core_reset), 32'h1);
        presetn <= 1'b1;
        rd(A_STATUS, 32'h3);
        rd(A_WDEDGE, 32'h80);
        rd(A_FLAGS, 32'h0);
        $display("test power-on again done");
        stop_test();
    end
endmodule
